// ==== clst_pkg.sv ====
// Notes on behaviour
// R01: function select 0 keeps the step output off regardless of inputs.
// R02: function select 1 feeds input 1 straight into the timer stage.
// R03: selects 2, 3, 4 combine both inputs by AND, OR, XOR into the timer.
// R04: select 5: input 1 sets, else input 2 clears, else output holds.
// R05: select 6: input 2 clears, else input 1 sets, else output holds.
// R06: select 7: each rising edge of input 1 gives one 2 ms pulse.
// R07: select 8: each falling edge of input 1 gives one 2 ms pulse.
// R08: select 9: every edge of input 1 gives one 2 ms pulse.
// R09: select 10: pass input 1 while input 2 is off, freeze it while on.
// R10: select 11: count rising edges of input 1, output on at target.
// R11: up counter clears to zero while input 2 is on.
// R12: select 12: count rising edges down, output on at zero.
// R13: down counter reloads the setting while input 2 is on.
// R14: select 13: rising input starts a timed pulse that ends on expiry.
// R15: timer select 13: input 2 on clears elapsed time and output.
// R16: timer 1: output on after input held on a period, off at once.
// R17: timer 2: output on at once, off after input held off a period.
// R18: timer 3: a turn-on while no pulse runs gives one pulse of the configured length.
// R19: timer 4: one-shot, a turn-on during the pulse restarts it.
// R20: timer 5: while input on, output alternates on and off each period.
// R21: the whole step is evaluated once per 2 ms processing tick.
// R22: setting spans 0.00 to 600.00 s; as a count it is used unscaled.
// R23: both inputs are sampled together at the start of each tick.
// R24: timer type 0 passes the logic result through unchanged.
// R25: periods are whole ticks, rounded up to a tick boundary.
`default_nettype none
package clst_pkg;
    // clock and processing tick
    localparam int CLK_PERIOD_NS  = 4;
    localparam int TICK_NS        = 2000000;
    localparam int TICK_CYCLES    = (TICK_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    // one setting step is 0.01 s, i.e. five 2 ms ticks
    localparam int SET_UNIT_US    = 10000;
    localparam int TICK_US        = 2000;
    localparam int TICKS_PER_UNIT = (SET_UNIT_US + TICK_US - 1) / TICK_US;
    // setting and counter widths
    localparam int SW             = 16;
    localparam int CW             = 19;
    localparam logic [SW-1:0] SET_MAX = 16'hEA60;
    localparam logic [CW-1:0] CNT_MAX = 19'h7FFFF;
    // register map, byte offsets
    localparam int AW             = 8;
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_SET  = 8'h04;
    localparam logic [AW-1:0] ADDR_STAT = 8'h08;
    // field layout and reset values
    localparam int CTRL_W         = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    localparam logic [SW-1:0]     SET_RST  = 16'h0000;
    localparam int STAT_PAD_W     = 8;

    typedef enum logic [3:0] {
        LF_OFF   = 4'h0,
        LF_THRU  = 4'h1,
        LF_AND   = 4'h2,
        LF_OR    = 4'h3,
        LF_XOR   = 4'h4,
        LF_SET   = 4'h5,
        LF_RESET = 4'h6,
        LF_RISE  = 4'h7,
        LF_FALL  = 4'h8,
        LF_BOTH  = 4'h9,
        LF_HOLD  = 4'hA,
        LF_UP    = 4'hB,
        LF_DOWN  = 4'hC,
        LF_TIMER = 4'hD
    } clst_lf_t;

    typedef enum logic [2:0] {
        TT_NONE  = 3'h0,
        TT_ON    = 3'h1,
        TT_OFF   = 3'h2,
        TT_SHOT  = 3'h3,
        TT_RETRG = 3'h4,
        TT_TRAIN = 3'h5
    } clst_tt_t;

    typedef struct packed {
        clst_tt_t timer_type_select;
        clst_lf_t logic_function_select;
    } clst_cfg_t;

    typedef struct packed {
        logic b;
        logic a;
    } clst_pin_t;
endpackage
`default_nettype wire

// ==== clst_top.sv ====
`default_nettype none
module clst_top #(
    parameter int TICK_CYCLES = clst_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    // step inputs from terminals or other steps
    input  wire logic        in1_i,
    input  wire logic        in2_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // step result
    output logic             step_o
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
    localparam int CW = clst_pkg::CW;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    // two-stage synchronisers for the external inputs
    clst_pkg::clst_pin_t pin_meta;
    clst_pkg::clst_pin_t pin_sync;
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= {in2_i, in1_i};
            pin_sync <= pin_meta;
        end
    end

    // processing tick divider
    logic [TW-1:0] tick_cnt;
    logic [TW-1:0] next_tick_cnt;
    logic          tick;
    logic          next_tick;
    always_comb
    begin
        next_tick     = (tick_cnt == TICK_LAST);
        next_tick_cnt = next_tick ? '0 : tick_cnt + TW'(1);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            tick     <= next_tick;
        end
    end

    // software-visible configuration
    clst_pkg::clst_cfg_t cfg;
    clst_pkg::clst_cfg_t next_cfg;
    logic [clst_pkg::SW-1:0] cfg_set;
    logic [clst_pkg::SW-1:0] next_cfg_set;

    // step state
    clst_pkg::clst_pin_t smp;
    clst_pkg::clst_pin_t next_smp;
    clst_pkg::clst_pin_t cur;
    logic          lq;
    logic          next_lq;
    logic [CW-1:0] lcnt;
    logic [CW-1:0] next_lcnt;
    logic [CW-1:0] trem;
    logic [CW-1:0] next_trem;
    logic          tout;
    logic          next_tout;
    logic          lprev;
    logic          next_lprev;
    logic          next_step;
    logic          rise;
    logic          fall;
    logic          trig;
    logic          lres;
    logic          direct;
    logic [CW-1:0] per;
    logic [CW-1:0] tgt;

    // logic function then timer stage, evaluated only on the tick
    always_comb
    begin
        cur        = pin_sync;
        rise       = cur.a & ~smp.a;
        fall       = ~cur.a & smp.a;
        // setting steps are exact multiples of a tick, no rounding loss
        per        = CW'(cfg_set) * CW'(clst_pkg::TICKS_PER_UNIT); // see R25
        tgt        = CW'(cfg_set); // see R22
        next_smp   = smp;
        next_lq    = lq;
        next_lcnt  = lcnt;
        next_trem  = trem;
        next_tout  = tout;
        next_lprev = lprev;
        next_step  = step_o;
        lres       = 1'b0;
        direct     = 1'b0;
        trig       = 1'b0;
        if (tick) // see R21
        begin
            next_smp = cur; // see R23
            case (cfg.logic_function_select)
                clst_pkg::LF_THRU:  lres = cur.a; // see R02
                clst_pkg::LF_AND:   lres = cur.a & cur.b; // see R03
                clst_pkg::LF_OR:    lres = cur.a | cur.b; // see R03
                clst_pkg::LF_XOR:   lres = cur.a ^ cur.b; // see R03
                clst_pkg::LF_SET:
                begin
                    lres    = cur.a | (~cur.b & lq); // see R04
                    next_lq = lres;
                end
                clst_pkg::LF_RESET:
                begin
                    lres    = ~cur.b & (cur.a | lq); // see R05
                    next_lq = lres;
                end
                clst_pkg::LF_RISE:  lres = rise; // see R06
                clst_pkg::LF_FALL:  lres = fall; // see R07
                clst_pkg::LF_BOTH:  lres = rise | fall; // see R08
                clst_pkg::LF_HOLD:
                begin
                    lres    = cur.b ? lq : cur.a; // see R09
                    next_lq = lres;
                end
                clst_pkg::LF_UP:
                begin
                    direct = 1'b1;
                    if (cur.b)
                        next_lcnt = '0; // see R11
                    else if (rise && lcnt != clst_pkg::CNT_MAX)
                        next_lcnt = lcnt + CW'(1); // see R10
                    lres = (next_lcnt >= tgt); // see R10
                end
                clst_pkg::LF_DOWN:
                begin
                    direct = 1'b1;
                    if (cur.b)
                        next_lcnt = tgt; // see R13
                    else if (rise && lcnt != '0)
                        next_lcnt = lcnt - CW'(1); // see R12
                    lres = (next_lcnt == '0); // see R12
                end
                clst_pkg::LF_TIMER:
                begin
                    // lcnt holds the ticks left in the running pulse
                    direct = 1'b1;
                    if (cur.b)
                        next_lcnt = '0; // see R15
                    else if (rise && lcnt == '0)
                        next_lcnt = per; // see R14
                    else if (lcnt != '0)
                        next_lcnt = lcnt - CW'(1); // see R14
                    next_lq = (next_lcnt != '0);
                    lres    = next_lq;
                end
                default:            lres = 1'b0;
            endcase

            trig       = lres & ~lprev;
            next_lprev = lres;
            case (cfg.timer_type_select)
                clst_pkg::TT_ON:
                begin
                    // trem counts ticks held on, saturating
                    if (!lres)
                        next_trem = '0;
                    else if (trem != clst_pkg::CNT_MAX)
                        next_trem = trem + CW'(1);
                    next_tout = lres && (next_trem >= per); // see R16
                end
                clst_pkg::TT_OFF:
                begin
                    if (lres)
                    begin
                        next_trem = '0;
                        next_tout = 1'b1; // see R17
                    end
                    else if (tout)
                    begin
                        next_trem = trem + CW'(1);
                        next_tout = (next_trem < per); // see R17
                    end
                end
                clst_pkg::TT_SHOT, clst_pkg::TT_RETRG:
                begin
                    // timer 3 ignores edges while its pulse runs, timer 4 restarts the pulse
                    if (trig && (trem == '0 ||
                        cfg.timer_type_select == clst_pkg::TT_RETRG))
                        next_trem = per; // see R18 see R19
                    else if (trem != '0)
                        next_trem = trem - CW'(1);
                    next_tout = (next_trem != '0);
                end
                clst_pkg::TT_TRAIN:
                begin
                    if (!lres)
                    begin
                        next_trem = '0;
                        next_tout = 1'b0;
                    end
                    else if (trig)
                    begin
                        next_trem = per;
                        next_tout = 1'b1;
                    end
                    else if (trem <= CW'(1))
                    begin
                        next_trem = per;
                        next_tout = ~tout; // see R20
                    end
                    else
                        next_trem = trem - CW'(1);
                end
                default:
                begin
                    next_trem = '0;
                    next_tout = lres; // see R24
                end
            endcase
            // counters and select 13 carry no general-purpose timer
            next_step = direct ? lres : next_tout;
            if (cfg.logic_function_select == clst_pkg::LF_OFF)
            begin
                next_step = 1'b0; // see R01
                next_trem = '0;
                next_tout = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            smp    <= '0;
            lq     <= 1'b0;
            lcnt   <= '0;
            trem   <= '0;
            tout   <= 1'b0;
            lprev  <= 1'b0;
            step_o <= 1'b0;
        end
        else
        begin
            smp    <= next_smp;
            lq     <= next_lq;
            lcnt   <= next_lcnt;
            trem   <= next_trem;
            tout   <= next_tout;
            lprev  <= next_lprev;
            step_o <= next_step;
        end
    end

    // ahb-lite slave: writes zero-wait, reads take one wait state so
    // a read right behind a write sees the new value
    logic                    take;
    logic                    dp_wr;
    logic                    next_dp_wr;
    logic                    dp_rd;
    logic                    next_dp_rd;
    logic [clst_pkg::AW-1:0] dp_addr;
    logic [clst_pkg::AW-1:0] next_dp_addr;
    logic [31:0]             next_hrdata;
    logic                    next_hreadyout;
    always_comb
    begin
        take           = hsel_i & htrans_i[1] & hready_i;
        next_dp_wr     = take & hwrite_i;
        next_dp_rd     = take & ~hwrite_i;
        next_dp_addr   = take ? haddr_i[clst_pkg::AW-1:0] : dp_addr;
        next_hreadyout = ~next_dp_rd;
        next_hrdata    = hrdata_o;
        next_cfg       = cfg;
        next_cfg_set   = cfg_set;
        if (dp_wr)
        begin
            case (dp_addr)
                clst_pkg::ADDR_CTRL:
                    next_cfg = clst_pkg::clst_cfg_t'(
                        hwdata_i[clst_pkg::CTRL_W-1:0]);
                clst_pkg::ADDR_SET:
                    // clamp to 600.00 s
                    next_cfg_set = (hwdata_i[clst_pkg::SW-1:0] >
                        clst_pkg::SET_MAX) ? clst_pkg::SET_MAX
                        : hwdata_i[clst_pkg::SW-1:0]; // see R22
                default: ;
            endcase
        end
        if (dp_rd)
        begin
            case (dp_addr)
                clst_pkg::ADDR_CTRL:
                    next_hrdata = {{(32 - clst_pkg::CTRL_W){1'b0}}, cfg};
                clst_pkg::ADDR_SET:
                    next_hrdata = {{(32 - clst_pkg::SW){1'b0}}, cfg_set};
                clst_pkg::ADDR_STAT:
                    next_hrdata = {lcnt, {clst_pkg::STAT_PAD_W{1'b0}},
                        tout, lq, smp.b, smp.a, step_o};
                default:
                    next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            dp_wr       <= 1'b0;
            dp_rd       <= 1'b0;
            dp_addr     <= '0;
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            cfg         <= clst_pkg::clst_cfg_t'(clst_pkg::CTRL_RST);
            cfg_set     <= clst_pkg::SET_RST;
        end
        else
        begin
            dp_wr       <= next_dp_wr;
            dp_rd       <= next_dp_rd;
            dp_addr     <= next_dp_addr;
            hrdata_o    <= next_hrdata;
            hreadyout_o <= next_hreadyout;
            hresp_o     <= 1'b0;
            cfg         <= next_cfg;
            cfg_set     <= next_cfg_set;
        end
    end

    // checks on the step behaviour
    sequence s_eval(logic [3:0] lf);
        tick && cfg.logic_function_select == lf &&
            cfg.timer_type_select == clst_pkg::TT_NONE;
    endsequence

    sequence s_thru(logic [2:0] tt);
        tick && cfg.logic_function_select == clst_pkg::LF_THRU &&
            cfg.timer_type_select == tt;
    endsequence

    chk_off_mode: assert property ( // see R01
        tick && cfg.logic_function_select == clst_pkg::LF_OFF |=> !step_o)
        else $error("step on with function off");
    chk_thru_path: assert property ( // see R02 see R24
        s_eval(clst_pkg::LF_THRU) |=> step_o == $past(pin_sync.a))
        else $error("through path mismatch");
    chk_and_gate: assert property ( // see R03
        s_eval(clst_pkg::LF_AND) |=>
            step_o == ($past(pin_sync.a) && $past(pin_sync.b)))
        else $error("and result mismatch");
    chk_set_prio: assert property ( // see R04
        s_eval(clst_pkg::LF_SET) ##0 pin_sync.a |=> step_o)
        else $error("set priority lost");
    chk_reset_prio: assert property ( // see R05
        s_eval(clst_pkg::LF_RESET) ##0 pin_sync.b |=> !step_o)
        else $error("reset priority lost");
    chk_both_edges: assert property ( // see R08
        s_eval(clst_pkg::LF_BOTH) |=>
            step_o == ($past(pin_sync.a) ^ $past(smp.a)))
        else $error("edge pulse mismatch");
    chk_hold_freeze: assert property ( // see R09
        s_eval(clst_pkg::LF_HOLD) ##0 pin_sync.b |=> $stable(step_o))
        else $error("hold did not freeze");
    chk_up_clear: assert property ( // see R11
        tick && cfg.logic_function_select == clst_pkg::LF_UP &&
            pin_sync.b |=> lcnt == '0)
        else $error("up count not cleared");
    chk_down_load: assert property ( // see R13
        tick && cfg.logic_function_select == clst_pkg::LF_DOWN &&
            pin_sync.b |=> lcnt == CW'($past(cfg_set)))
        else $error("down count not reloaded");
    chk_timer_clear: assert property ( // see R15
        tick && cfg.logic_function_select == clst_pkg::LF_TIMER &&
            pin_sync.b |=> !step_o && lcnt == '0)
        else $error("timer reset ignored");
    chk_ondly_drop: assert property ( // see R16
        s_thru(clst_pkg::TT_ON) ##0 !pin_sync.a |=> !step_o)
        else $error("on-delay output not dropped");
    chk_offdly_on: assert property ( // see R17
        s_thru(clst_pkg::TT_OFF) ##0 pin_sync.a |=> step_o)
        else $error("off-delay output not raised");
    chk_tick_only: assert property ( // see R21
        !$past(tick) |-> $stable(step_o) && $stable(smp))
        else $error("step changed between ticks");
    chk_sample_both: assert property ( // see R23
        tick |=> smp == $past(pin_sync))
        else $error("inputs not sampled together");
endmodule
`default_nettype wire

// ==== clst_far_model.sv ====
`default_nettype none
// far-side terminals: a requested level reaches the pins after a lag
module clst_far_model (
    // clock
    input  wire logic                clk_sys_i,
    // requested levels and settling lag in cycles
    input  wire clst_pkg::clst_pin_t want_i,
    input  wire logic [3:0]          lag_i,
    // terminal pins toward the step
    output var  clst_pkg::clst_pin_t pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    clst_pkg::clst_pin_t pend;
    logic [3:0]          wait_cnt;

    // pins idle low until the bench asks for something else
    initial
    begin
        pend     = '0;
        pin_o    = '0;
        wait_cnt = 4'h0;
    end

    // a new request restarts the lag, so slow terminals stay repeatable
    always @(posedge clk_sys_i)
    begin
        if (want_i != pend)
        begin
            pend     <= want_i;
            wait_cnt <= lag_i;
        end
        else if (wait_cnt != 4'h0)
            wait_cnt <= wait_cnt - 4'h1;
        else
            pin_o <= pend;
    end
endmodule
`default_nettype wire

// ==== clst_bench.sv ====
`default_nettype none
module clst_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int T = 8;  // short tick keeps the run brief

    // one timed input pattern and the step-high time it should give
    typedef struct {
        logic [7:0] cfg;
        int         hi1;
        int         lo;
        int         hi2;
        int         win;
        int         exp_t;
    } clst_row_t;

    logic                clk_sys_i = 1'b0;
    logic                resetn_i  = 1'b0;
    logic                hsel_i    = 1'b0;
    logic [31:0]         haddr_i   = 32'h0;
    logic [1:0]          htrans_i  = 2'h0;
    logic                hwrite_i  = 1'b0;
    logic [31:0]         hwdata_i  = 32'h0;
    logic [31:0]         hrdata_o;
    logic                hreadyout_o;
    logic                hresp_o;
    logic                step_o;
    clst_pkg::clst_pin_t want      = '0;
    clst_pkg::clst_pin_t pin;
    logic [3:0]          lag       = 4'h0;
    logic [31:0]         rd;
    logic                q;
    logic                x1;
    logic                x2;
    logic [1:0]          l2;
    int                  n;
    int                  fail_count = 0;
    int                  num_checks = 0;
    logic [3:0]          lvl_modes[8] = '{4'h0, 4'h1, 4'h2, 4'h3,
                                          4'h4, 4'h5, 4'h6, 4'hA};
    clst_row_t           rows[13] = '{
        '{8'h01, 4, 0, 0, 8, 4},
        '{8'h07, 4, 0, 0, 8, 1},
        '{8'h08, 4, 0, 0, 8, 1},
        '{8'h09, 4, 0, 0, 8, 2},
        '{8'h31, 8, 0, 0, 12, 5},
        '{8'h31, 2, 1, 1, 14, 5},
        '{8'h41, 2, 1, 1, 14, 8},
        '{8'h0D, 2, 1, 1, 14, 5},
        '{8'h11, 8, 0, 0, 12, 4},
        '{8'h11, 3, 0, 0, 8, 0},
        '{8'h21, 3, 0, 0, 12, 7},
        '{8'h51, 20, 0, 0, 24, 10},
        '{8'h30, 4, 0, 0, 8, 0}};

    clst_top #(.TICK_CYCLES(T)) dut_u (
        .clk_sys_i  (clk_sys_i),
        .resetn_i   (resetn_i),
        .in1_i      (pin.a),
        .in2_i      (pin.b),
        .hsel_i     (hsel_i),
        .haddr_i    (haddr_i),
        .htrans_i   (htrans_i),
        .hwrite_i   (hwrite_i),
        .hsize_i    (3'h2),
        .hwdata_i   (hwdata_i),
        .hready_i   (hreadyout_o),
        .hrdata_o   (hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o    (hresp_o),
        .step_o     (step_o)
    );

    clst_far_model far_u (
        .clk_sys_i(clk_sys_i),
        .want_i   (want),
        .lag_i    (lag),
        .pin_o    (pin)
    );

    // 250 MHz system clock
    initial
    begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] got);
        num_checks++;
        if (got !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic chk_step(input string what, input logic e);
        check(what, {31'h0, e}, {31'h0, step_o});
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // single word transfer; only hready decides when each phase ends
    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] d);
        @(posedge clk_sys_i);
        hsel_i   <= 1'b1;
        haddr_i  <= {24'h0, a};
        htrans_i <= 2'h2;
        hwrite_i <= w;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        d = hrdata_o;
        check("hresp", 32'h0, {31'h0, hresp_o});
    endtask

    task automatic cfg(input logic [7:0] c, input logic [15:0] s);
        ahb(clst_pkg::ADDR_CTRL, 1'b1, {24'h0, c}, rd);
        ahb(clst_pkg::ADDR_SET, 1'b1, {16'h0, s}, rd);
    endtask

    // called just after a rising edge, so no extra cycle creeps in
    task automatic drive(input logic a, input logic b, input logic [3:0] l);
        want.a <= a;
        want.b <= b;
        lag    <= l;
    endtask

    task automatic ticks(input int k);
        repeat (k * T) @(posedge clk_sys_i);
    endtask

    // level model of functions that need no timer
    function automatic logic step_exp(input logic [3:0] m, input logic a,
                                      input logic b, input logic p);
        case (m)
            4'h0: return 1'b0;
            4'h1: return a;
            4'h2: return a & b;
            4'h3: return a | b;
            4'h4: return a ^ b;
            4'h5: return a ? 1'b1 : (b ? 1'b0 : p);
            4'h6: return b ? 1'b0 : (a ? 1'b1 : p);
            default: return b ? p : a;
        endcase
    endfunction

    // plays one row on input 1 while counting cycles with the step high
    task automatic pulse_run(input clst_row_t r, output int cnt);
        cnt = 0;
        fork
            begin
                drive(1'b1, 1'b0, 4'h0);
                ticks(r.hi1);
                if (r.lo > 0)
                begin
                    drive(1'b0, 1'b0, 4'h0);
                    ticks(r.lo);
                    drive(1'b1, 1'b0, 4'h0);
                    ticks(r.hi2);
                end
                drive(1'b0, 1'b0, 4'h0);
            end
            repeat (r.win * T)
            begin
                @(posedge clk_sys_i);
                cnt += int'(step_o === 1'b1);
            end
        join
    endtask

    // watchdog well beyond the expected few thousand cycles
    initial
    begin
        repeat (40000) @(posedge clk_sys_i);
        fail_count++;
        wrap_up();
    end

    // main sequence
    initial
    begin
        void'($urandom(32'h918B));
        repeat (20) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        chk_step("step after reset", 1'b0);
        ahb(clst_pkg::ADDR_CTRL, 1'b0, 32'h0, rd);
        check("ctrl reset", 32'h0, rd);
        ahb(8'h0C, 1'b0, 32'h0, rd);
        check("unmapped read", 32'h0, rd);
        cfg(8'h00, 16'hFFFF);
        ahb(clst_pkg::ADDR_SET, 1'b0, 32'h0, rd);
        check("setting clamp", 32'h0000EA60, rd);
        // level functions with random inputs and random terminal lag
        foreach (lvl_modes[i])
        begin
            cfg({4'h0, lvl_modes[i]}, 16'h0);
            drive(1'b0, 1'b1, 4'h0);
            ticks(3);
            drive(1'b0, 1'b0, 4'h0);
            ticks(3);
            q = 1'b0;
            repeat (10)
            begin
                {x2, x1, l2} = 4'($urandom);
                drive(x1, x2, {2'h0, l2});
                ticks(3);
                q = step_exp(lvl_modes[i], x1, x2, q);
                chk_step("step level", q);
            end
        end
        // timed patterns; setting 1 is a five-tick period
        // a random level left high would hide the first rise of row 0
        drive(1'b0, 1'b0, 4'h0);
        foreach (rows[i])
        begin
            cfg(rows[i].cfg, 16'h0001);
            ticks(2);
            pulse_run(rows[i], n);
            check("pulse cycles", 32'(rows[i].exp_t * T), 32'(n));
        end
        // up counter to three, then cleared by input 2
        cfg(8'h0B, 16'h0003);
        drive(1'b0, 1'b1, 4'h0);
        ticks(2);
        for (int k = 1; k <= 3; k++)
        begin
            drive(1'b1, 1'b0, 4'h0);
            ticks(2);
            drive(1'b0, 1'b0, 4'h0);
            ticks(2);
            chk_step("up count", 1'(k >= 3));
        end
        ahb(clst_pkg::ADDR_STAT, 1'b0, 32'h0, rd);
        check("up value", 32'h3, {13'h0, rd[31:13]});
        drive(1'b0, 1'b1, 4'h0);
        ticks(3);
        chk_step("up clear", 1'b0);
        ahb(clst_pkg::ADDR_STAT, 1'b0, 32'h0, rd);
        check("up zero", 32'h0, {13'h0, rd[31:13]});
        // down counter from two, reloaded by input 2
        cfg(8'h0C, 16'h0002);
        ticks(2);
        chk_step("down reload", 1'b0);
        drive(1'b0, 1'b0, 4'h0);
        ticks(2);
        for (int k = 1; k <= 2; k++)
        begin
            drive(1'b1, 1'b0, 4'h0);
            ticks(2);
            drive(1'b0, 1'b0, 4'h0);
            ticks(2);
            chk_step("down count", 1'(k >= 2));
        end
        drive(1'b0, 1'b1, 4'h0);
        ticks(3);
        chk_step("down again", 1'b0);
        // resettable timer cut short by input 2
        cfg(8'h0D, 16'h0001);
        ticks(1); // input 2 still on, clears the count left by mode 12
        drive(1'b1, 1'b0, 4'h0);
        ticks(2);
        chk_step("timer running", 1'b1);
        drive(1'b1, 1'b1, 4'h0);
        ticks(2);
        chk_step("timer reset", 1'b0);
        drive(1'b0, 1'b0, 4'h0);
        ticks(2);
        wrap_up();
    end
endmodule
`default_nettype wire
